// ===== verilog/ccrc_ctl.sv
`timescale 1ns/100ps
`default_nettype none

module ccrc_ctl
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  // host i/o cycle
  input  wire logic        host_io_req,
  input  wire logic        host_io_wr,
  input  wire logic [15:0] host_io_addr,
  input  wire logic [7:0]  host_be_n,
  input  wire logic [63:0] host_wdata,
  output logic             host_ready_q,
  output logic             host_done_q,
  output logic [63:0]      host_rdata_q,
  // pci master request
  output logic             pci_req_q,
  output logic [3:0]       pci_cmd_q,
  output logic [31:0]      pci_addr_q,
  output logic [3:0]       pci_be_n_q,
  output logic [31:0]      pci_wdata_q,
  input  wire logic        pci_done,
  input  wire logic [31:0] pci_rdata,
  // own configuration space
  output logic             own_cfg_req_q,
  output logic             pci_devsel_n_q,
  output logic             pci_devsel_oe_q,
  input  wire logic [31:0] own_cfg_rdata,
  // cpu reset lines
  output logic             cpu_hard_reset_line,
  output logic             cpu_init_line,
  output logic             cpu_self_test
);

  // ------------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------------
  ccrc_pkg::ccrc_state_e                st_q;
  logic [31:0]                          latch_q;
  logic [7:0]                           rstc_q;
  logic                                 rd_q;
  logic [ccrc_pkg::DEV_LINES-1:0]       dev_lines;

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  logic        take;
  logic        qw_hit;
  logic [3:0]  lo_en;
  logic [3:0]  hi_en;
  logic        is_lat;
  logic        is_rst;
  logic        is_cfg;
  logic        use_hi;
  logic        type0;
  logic        own;
  logic [31:0] cfg_addr;
  logic [31:0] fwd_addr;
  logic [7:0]  rc_new;
  logic        go_rise;
  logic        hard_trig;
  logic        soft_trig;
  logic        rst_trig;
  logic        init_trig;
  logic        cpu_self_test_trig;

  assign take   = host_io_req && (st_q == ccrc_pkg::ST_IDLE);
  assign qw_hit = host_io_addr[15:3] == ccrc_pkg::CFG_ADDR_PORT[15:3];
  assign lo_en  = ~host_be_n[3:0];
  assign hi_en  = ~host_be_n[7:4];
  // only a whole dword on the low lanes reaches the latch
  assign is_lat = qw_hit && (lo_en == 4'hF) && (hi_en == 4'h0);
  // a lone byte at the next port is the reset control register
  assign is_rst = qw_hit && (lo_en == 4'h2) && (hi_en == 4'h0);
  // any data window lane with the enable set becomes a cfg cycle
  assign is_cfg = qw_hit && (hi_en != 4'h0)
                  && latch_q[ccrc_pkg::LAT_EN_BIT];
  assign use_hi = (lo_en == 4'h0);
  assign type0  = latch_q[ccrc_pkg::LAT_BUS_HI:ccrc_pkg::LAT_BUS_LO]
                  == 8'h00;
  assign own    = type0 &&
    (latch_q[ccrc_pkg::LAT_DEV_HI:ccrc_pkg::LAT_DEV_LO] == 5'h00);

  ccrc_dev_onehot u_dev
  (
    .dev   (latch_q[ccrc_pkg::LAT_DEV_HI:ccrc_pkg::LAT_DEV_LO]),
    .lines (dev_lines)
  );

  // type 0 carries the select line, type 1 the latch as written
  assign cfg_addr = type0 ? {dev_lines, latch_q[10:2], 2'b00}
                          : {latch_q[31:2], 2'b01};
  assign fwd_addr = {16'h0000, host_io_addr[15:3], use_hi, 2'b00};

  // ------------------------------------------------------------------
  // reset control decode
  // ------------------------------------------------------------------
  // bits 7:5 are masked off on write so they never steer anything
  assign rc_new    = host_wdata[15:8] & ccrc_pkg::RC_WR_MASK;
  // only the edge of go acts; relies on the two-write sequence
  assign go_rise   = take && is_rst && host_io_wr
                     && rc_new[ccrc_pkg::RC_GO] && !rstc_q[ccrc_pkg::RC_GO];
  assign hard_trig = go_rise && rc_new[ccrc_pkg::RC_HARD];
  assign soft_trig = go_rise && !rc_new[ccrc_pkg::RC_HARD];
  assign cpu_self_test_trig = hard_trig && rc_new[ccrc_pkg::RC_CPU_SELF_TEST_EN]
                     && rc_new[ccrc_pkg::RC_INIT_EN];
  assign rst_trig  = hard_trig
                     || (soft_trig && !rc_new[ccrc_pkg::RC_INIT_EN]);
  assign init_trig = (soft_trig && rc_new[ccrc_pkg::RC_INIT_EN])
                     || cpu_self_test_trig;

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // latch: writable bits only, reserved bits stay zero
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      latch_q <= ccrc_pkg::LAT_RESET;
    else if (take && is_lat && host_io_wr)
      latch_q <= host_wdata[31:0] & ccrc_pkg::LAT_WR_MASK;
  end

  // reset control register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rstc_q <= ccrc_pkg::RC_RESET;
    else if (take && is_rst && host_io_wr)
      rstc_q <= rc_new;
  end

  // ------------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------------
  // local registers answer next cycle; pci waits for the target
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      st_q            <= ccrc_pkg::ST_IDLE;
      host_ready_q    <= 1'b0;
      host_done_q     <= 1'b0;
      host_rdata_q    <= '0;
      rd_q            <= 1'b0;
      pci_req_q       <= 1'b0;
      pci_cmd_q       <= ccrc_pkg::CMD_IO_RD;
      pci_addr_q      <= '0;
      pci_be_n_q      <= 4'hF;
      pci_wdata_q     <= '0;
      own_cfg_req_q   <= 1'b0;
      pci_devsel_n_q  <= 1'b1;
      pci_devsel_oe_q <= 1'b0;
    end
    else
    begin
      host_done_q     <= 1'b0;
      own_cfg_req_q   <= 1'b0;
      pci_devsel_n_q  <= 1'b1;
      pci_devsel_oe_q <= 1'b0;
      host_ready_q    <= 1'b1;
      case (st_q)
        ccrc_pkg::ST_IDLE:
        begin
          if (take)
          begin
            rd_q <= !host_io_wr;
            if (is_lat || is_rst)
            begin
              host_done_q  <= 1'b1;
              host_rdata_q <= is_lat ? {32'h0, latch_q}
                                     : {48'h0, rstc_q & 8'h1F, 8'h00};
            end
            else if (is_cfg)
            begin
              host_ready_q <= 1'b0;
              pci_addr_q   <= cfg_addr;
              pci_be_n_q   <= host_be_n[7:4];
              pci_wdata_q  <= host_wdata[63:32];
              pci_cmd_q    <= host_io_wr ? ccrc_pkg::CMD_CFG_WR
                                         : ccrc_pkg::CMD_CFG_RD;
              if (own)
              begin
                // claim our own cycle; target logic answers next cycle
                own_cfg_req_q   <= 1'b1;
                pci_devsel_n_q  <= 1'b0;
                pci_devsel_oe_q <= 1'b1;
                st_q            <= ccrc_pkg::ST_OWN;
              end
              else
              begin
                pci_req_q <= 1'b1;
                st_q      <= ccrc_pkg::ST_PCI;
              end
            end
            else
            begin
              // plain i/o; one half only, the low lanes whenever any low lane is enabled
              host_ready_q <= 1'b0;
              pci_req_q    <= 1'b1;
              pci_addr_q   <= fwd_addr;
              pci_be_n_q   <= use_hi ? host_be_n[7:4] : host_be_n[3:0];
              pci_wdata_q  <= use_hi ? host_wdata[63:32] : host_wdata[31:0];
              pci_cmd_q    <= host_io_wr ? ccrc_pkg::CMD_IO_WR
                                         : ccrc_pkg::CMD_IO_RD;
              st_q         <= ccrc_pkg::ST_PCI;
            end
          end
        end
        ccrc_pkg::ST_PCI:
        begin
          host_ready_q <= 1'b0;
          if (pci_done)
          begin
            pci_req_q    <= 1'b0;
            host_done_q  <= 1'b1;
            host_ready_q <= 1'b1;
            // cfg data always rides the window lanes, whatever the index
            if (rd_q)
              host_rdata_q <= (pci_addr_q[2] || pci_cmd_q[3])
                              ? {pci_rdata, 32'h0}
                              : {32'h0, pci_rdata};
            st_q <= ccrc_pkg::ST_IDLE;
          end
        end
        ccrc_pkg::ST_OWN:
        begin
          host_done_q  <= 1'b1;
          if (rd_q)
            host_rdata_q <= {own_cfg_rdata, 32'h0};
          st_q <= ccrc_pkg::ST_IDLE;
        end
        default:
        begin
          pci_req_q <= 1'b0;
          st_q      <= ccrc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // cpu reset pulses
  // ------------------------------------------------------------------
  // one stretcher per line keeps each pulse exactly the set width
  ccrc_pulse_stretch
  #(
    .WIDTH (ccrc_pkg::CNT_W'(ccrc_pkg::RST_PULSE_CYC))
  )
  u_hard
  (
    .clock (clock),
    .rst_n (rst_n),
    .trig  (rst_trig),
    .out_q (cpu_hard_reset_line)
  );

  ccrc_pulse_stretch
  #(
    .WIDTH (ccrc_pkg::CNT_W'(ccrc_pkg::RST_PULSE_CYC))
  )
  u_init
  (
    .clock (clock),
    .rst_n (rst_n),
    .trig  (init_trig),
    .out_q (cpu_init_line)
  );

  ccrc_pulse_stretch
  #(
    .WIDTH (ccrc_pkg::CNT_W'(ccrc_pkg::RST_PULSE_CYC))
  )
  u_cpu_self_test
  (
    .clock (clock),
    .rst_n (rst_n),
    .trig  (cpu_self_test_trig),
    .out_q (cpu_self_test)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  property p_latch_load;
    @(posedge clock) disable iff (!rst_n)
    (take && is_lat && host_io_wr) |=>
      latch_q == ($past(host_wdata[31:0]) & ccrc_pkg::LAT_WR_MASK);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("latch not loaded by dword write");

  property p_latch_zero;
    @(posedge clock) disable iff (!rst_n)
    (latch_q[30:24] == 7'h00) && (latch_q[1:0] == 2'b00);
  endproperty
  a_latch_zero: assert property (p_latch_zero)
    else $error("reserved latch bits not zero");

  property p_latch_reset;
    @(posedge clock) $rose(rst_n) |-> !latch_q[ccrc_pkg::LAT_EN_BIT];
  endproperty
  a_latch_reset: assert property (p_latch_reset)
    else $error("latch enable set after reset");

  property p_partial_fwd;
    @(posedge clock) disable iff (!rst_n)
    (take && qw_hit && (hi_en == 4'h0) && (lo_en != 4'hF)
      && (lo_en != 4'h2) && (lo_en != 4'h0)) |=>
      pci_req_q && (pci_cmd_q[3:1] == 3'b001) && $stable(latch_q);
  endproperty
  a_partial_fwd: assert property (p_partial_fwd)
    else $error("partial latch access not forwarded");

  property p_window_plain;
    @(posedge clock) disable iff (!rst_n)
    (take && qw_hit && (hi_en != 4'h0) && !latch_q[31]) |=>
      pci_req_q && (pci_addr_q == {16'h0, ccrc_pkg::CFG_DATA_PORT});
  endproperty
  a_window_plain: assert property (p_window_plain)
    else $error("disabled window access not passed unchanged");

  sequence s_type0_take;
    take && is_cfg && type0 && !own && (latch_q[15:11] < 5'h15);
  endsequence
  property p_type0_addr;
    @(posedge clock) disable iff (!rst_n)
    s_type0_take |=> pci_req_q && (pci_addr_q[1:0] == 2'b00)
      && $onehot(pci_addr_q[31:11]) && (pci_cmd_q[3:1] == 3'b101)
      && (pci_addr_q[10:2] == $past(latch_q[10:2]));
  endproperty
  a_type0_addr: assert property (p_type0_addr)
    else $error("type 0 address phase wrong");

  property p_type1_addr;
    @(posedge clock) disable iff (!rst_n)
    (take && is_cfg && !type0) |=>
      pci_req_q && (pci_addr_q == {$past(latch_q[31:2]), 2'b01});
  endproperty
  a_type1_addr: assert property (p_type1_addr)
    else $error("type 1 address phase wrong");

  property p_cfg_be;
    @(posedge clock) disable iff (!rst_n)
    (take && is_cfg) |=> (pci_be_n_q == $past(host_be_n[7:4]));
  endproperty
  a_cfg_be: assert property (p_cfg_be)
    else $error("cfg byte enables not from upper lanes");

  property p_own_claim;
    @(posedge clock) disable iff (!rst_n)
    (take && is_cfg && own) |=> !pci_devsel_n_q && !pci_req_q
      ##1 host_done_q;
  endproperty
  a_own_claim: assert property (p_own_claim)
    else $error("own cfg cycle not claimed");

  property p_soft_reset;
    @(posedge clock) disable iff (!rst_n)
    soft_trig |=> (cpu_init_line == $past(rc_new[4]))
      && (cpu_hard_reset_line == !$past(rc_new[4]));
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset on wrong line");

  property p_hard_reset;
    @(posedge clock) disable iff (!rst_n)
    hard_trig |=> cpu_hard_reset_line [*8];
  endproperty
  a_hard_reset: assert property (p_hard_reset)
    else $error("hard reset pulse missing or short");

  property p_cpu_self_test;
    @(posedge clock) disable iff (!rst_n)
    cpu_self_test_trig |=> cpu_self_test && cpu_init_line && cpu_hard_reset_line;
  endproperty
  a_cpu_self_test: assert property (p_cpu_self_test)
    else $error("self-test reset incomplete");

endmodule

`default_nettype wire

// ===== common/ccrc_pkg.sv
package ccrc_pkg;

  // ------------------------------------------------------------------
  // i/o port map
  // ------------------------------------------------------------------
  localparam logic [15:0] CFG_ADDR_PORT = 16'h0CF8;
  localparam logic [15:0] RST_CTL_PORT  = 16'h0CF9;
  localparam logic [15:0] CFG_DATA_PORT = 16'h0CFC;

  // ------------------------------------------------------------------
  // address latch fields
  // ------------------------------------------------------------------
  localparam int          LAT_EN_BIT  = 31;
  localparam int          LAT_BUS_HI  = 23;
  localparam int          LAT_BUS_LO  = 16;
  localparam int          LAT_DEV_HI  = 15;
  localparam int          LAT_DEV_LO  = 11;
  localparam logic [31:0] LAT_WR_MASK = 32'h80FF_FFFC;
  localparam logic [31:0] LAT_RESET   = 32'h0000_0000;
  localparam int          DEV_LINES   = 21;

  // ------------------------------------------------------------------
  // reset control register fields
  // ------------------------------------------------------------------
  localparam int          RC_INIT_EN  = 4;
  localparam int          RC_CPU_SELF_TEST_EN  = 3;
  localparam int          RC_GO       = 2;
  localparam int          RC_HARD     = 1;
  localparam logic [7:0]  RC_WR_MASK  = 8'h1F;
  localparam logic [7:0]  RC_RESET    = 8'h00;

  // ------------------------------------------------------------------
  // pci commands
  // ------------------------------------------------------------------
  localparam logic [3:0]  CMD_IO_RD   = 4'h2;
  localparam logic [3:0]  CMD_IO_WR   = 4'h3;
  localparam logic [3:0]  CMD_CFG_RD  = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR  = 4'hB;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          RST_PULSE_NS  = 1000;
  localparam int          RST_PULSE_CYC =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W = 8;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_PCI  = 3'b010,
    ST_OWN  = 3'b100
  } ccrc_state_e;

endpackage

// ===== verilog/ccrc_dev_onehot.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// device number to select line decode
// ------------------------------------------------------------------
module ccrc_dev_onehot
(
  input  wire logic [4:0]                   dev,
  output logic      [ccrc_pkg::DEV_LINES-1:0] lines
);

  // numbers at or above the line count select nothing
  always_comb
  begin
    lines = '0;
    if (32'(dev) < ccrc_pkg::DEV_LINES)
      lines[dev] = 1'b1;
  end

endmodule

`default_nettype wire

// ===== verilog/ccrc_pulse_stretch.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// trigger to fixed-width pulse
// ------------------------------------------------------------------
module ccrc_pulse_stretch
#(
  parameter logic [ccrc_pkg::CNT_W-1:0] WIDTH = 8'h28
)
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      out_q
);

  logic [ccrc_pkg::CNT_W-1:0] count_q;

  // a new trigger restarts the pulse at full width
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
      out_q   <= 1'b0;
    end
    else
    begin
      if (trig)
        count_q <= WIDTH;
      else if (count_q != '0)
        count_q <= count_q - 1'b1;
      out_q <= trig | (count_q > 8'h01);
    end
  end

endmodule

`default_nettype wire

// ===== tb/ccrc_pci_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// pci target model
// ------------------------------------------------------------------
module ccrc_pci_model
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  lag,
  input  wire logic        pci_req_q,
  input  wire logic [31:0] pci_addr_q,
  output logic             pci_done,
  output logic [31:0]      pci_rdata
);
  logic       busy;
  logic [3:0] cnt;

  // answer lag+1 cycles after taking the request; read data toggles outside done so a stale
  // sample can never pass for a good one
  always_ff @(posedge clock)
  begin
    pci_done  <= 1'b0;
    pci_rdata <= ~pci_rdata;
    if (!rst_n)
    begin
      busy      <= 1'b0;
      cnt       <= 4'h0;
      pci_rdata <= 32'h0;
    end
    else if (busy)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h0)
      begin
        busy      <= 1'b0;
        pci_done  <= 1'b1;
        pci_rdata <= pci_addr_q ^ 32'h5A5A_C3C3;
      end
    end
    else if (pci_req_q && !pci_done)
    begin
      busy <= 1'b1;
      cnt  <= lag;
    end
  end
endmodule
`default_nettype wire

// ===== tb/ccrc_ctl_bench.sv
`timescale 1ns/100ps
`default_nettype none

module ccrc_ctl_bench;
  logic        clock  = 1'b0;
  logic        rst_n  = 1'b0;
  logic        req    = 1'b0;
  logic        wr     = 1'b0;
  logic [15:0] addr   = 16'h0;
  logic [7:0]  be_n   = 8'hFF;
  logic [63:0] wdata  = 64'h0;
  logic [31:0] own_rd = 32'h0;
  logic [3:0]  lag    = 4'h0;
  logic        ready, done, p_req, p_done, own_req, dsel_n, dsel_oe;
  logic        hard, init, st, s_pci, s_own, s_dsel;
  logic [63:0] rdata, c_rd;
  logic [3:0]  p_cmd, p_be, c_cmd, c_be;
  logic [31:0] p_addr, p_wd, p_rd, c_addr, c_wd;
  logic [7:0]  rc [4] = '{8'hF0, 8'h00, 8'h02, 8'h1A};
  logic [2:0]  rx [4] = '{3'b010, 3'b100, 3'b100, 3'b111};
  int          n_errors     = 0;
  int          total_checks = 0;

  // ------------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------------
  always #12.5 clock = ~clock;

  ccrc_ctl u_ccrc_ctl
  (
    .clock(clock), .rst_n(rst_n), .host_io_req(req), .host_io_wr(wr),
    .host_io_addr(addr), .host_be_n(be_n), .host_wdata(wdata),
    .host_ready_q(ready), .host_done_q(done), .host_rdata_q(rdata),
    .pci_req_q(p_req), .pci_cmd_q(p_cmd), .pci_addr_q(p_addr),
    .pci_be_n_q(p_be), .pci_wdata_q(p_wd), .pci_done(p_done),
    .pci_rdata(p_rd), .own_cfg_req_q(own_req), .pci_devsel_n_q(dsel_n),
    .pci_devsel_oe_q(dsel_oe), .own_cfg_rdata(own_rd),
    .cpu_hard_reset_line(hard), .cpu_init_line(init), .cpu_self_test(st)
  );

  ccrc_pci_model u_ccrc_pci_model
  (
    .clock(clock), .rst_n(rst_n), .lag(lag), .pci_req_q(p_req),
    .pci_addr_q(p_addr), .pci_done(p_done), .pci_rdata(p_rd)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // expected address phase for a latch value
  function automatic logic [31:0] exp_ad(input logic [31:0] l);
    if (l[23:16] != 8'h0)
      return (l & 32'h80FF_FFFC) | 32'h1;
    return (32'h800 << l[15:11]) | (l & 32'h7FC);
  endfunction

  // one host i/o cycle; req drops after the take so it is not retaken,
  // and whatever the pci side or own claim showed is captured
  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] b, input logic [63:0] d);
    int k;
    @(posedge clock);
    #1;
    {req, wr, addr, be_n, wdata} = {1'b1, w, a, b, d};
    {s_pci, s_own, s_dsel} = 3'b000;
    @(posedge clock);
    #1;
    req = 1'b0;
    for (k = 0; k < 60 && done !== 1'b1; k++)
    begin
      if (p_req === 1'b1)
        {s_pci, c_cmd, c_be, c_addr, c_wd} = {1'b1, p_cmd, p_be, p_addr, p_wd};
      if (own_req === 1'b1)
        {s_own, s_dsel} = {1'b1, dsel_n === 1'b0 && dsel_oe === 1'b1};
      @(posedge clock);
      #1;
    end
    if (k == 60)
    begin
      n_errors++;
      report_and_stop();
    end
    c_rd = rdata;
    chk(ready, 1'b1);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    logic [31:0] lat, v;
    logic [7:0]  b;
    int          i, k;
    void'($urandom(32'h8E9B7DF4));
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clock);
    io(0, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, 64'h0);
    chk(c_rd[31:0], 32'h0);
    // random latch values, reserved bits must read back zero
    for (i = 0; i < 6; i++)
    begin
      v = $urandom;
      io(1, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, {32'h0, v});
      io(0, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, 64'h0);
      chk(c_rd[31:0], v & 32'h80FF_FFFC);
    end
    io(1, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, 64'h0);
    // narrow access at the latch port goes out as plain i/o
    io(1, ccrc_pkg::CFG_ADDR_PORT, 8'hFE, 64'hFFFF_FFFF);
    chk({s_pci, c_cmd}, {1'b1, ccrc_pkg::CMD_IO_WR});
    chk(c_addr, {16'h0, ccrc_pkg::CFG_ADDR_PORT});
    io(0, ccrc_pkg::CFG_ADDR_PORT, 8'hFC, 64'h0);
    chk({s_pci, c_cmd}, {1'b1, ccrc_pkg::CMD_IO_RD});
    io(0, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, 64'h0);
    chk(c_rd[31:0], 32'h0);
    io(0, ccrc_pkg::CFG_DATA_PORT, 8'h0F, 64'h0);
    chk({s_pci, c_cmd}, {1'b1, ccrc_pkg::CMD_IO_RD});
    chk(c_addr, {16'h0, ccrc_pkg::CFG_DATA_PORT});
    // translated cycles: bus 0 first, then non-zero buses
    for (i = 0; i < 16; i++)
    begin
      lat = {1'b1, 7'h0, 8'h0, 5'($urandom_range(20, 1)), 11'($urandom)};
      if (i >= 10)
        lat[23:16] = 8'($urandom_range(255, 1));
      v = $urandom;
      b = {4'($urandom_range(14, 0)), 4'hF};
      lag = 4'($urandom_range(5, 0));
      io(1, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, {32'h0, lat});
      io(i[0], ccrc_pkg::CFG_DATA_PORT, b, {v, 32'h0});
      chk({s_pci, c_cmd}, {1'b1, i[0] ? 4'hB : 4'hA});
      chk(c_addr, exp_ad(lat));
      chk(c_be, b[7:4]);
      if (i[0])
        chk(c_wd, v);
      else
        chk(c_rd[63:32], exp_ad(lat) ^ 32'h5A5A_C3C3);
    end
    // own device 0 on bus 0 is claimed locally
    own_rd = $urandom;
    lat = {1'b1, 15'h0, 5'h0, 9'($urandom), 2'b00};
    io(1, ccrc_pkg::CFG_ADDR_PORT, 8'hF0, {32'h0, lat});
    io(0, ccrc_pkg::CFG_DATA_PORT, 8'h0F, 64'h0);
    chk({s_pci, s_own, s_dsel}, 3'b011);
    chk(c_rd[63:32], own_rd);
    // two-step reset starts, each kind once
    for (i = 0; i < 4; i++)
    begin
      io(1, ccrc_pkg::RST_CTL_PORT, 8'hFD, {48'h0, rc[i], 8'h0});
      io(0, ccrc_pkg::RST_CTL_PORT, 8'hFD, 64'h0);
      chk(c_rd[15:8], rc[i] & 8'h1F);
      chk({hard, init, st}, 3'b000);
      io(1, ccrc_pkg::RST_CTL_PORT, 8'hFD, {48'h0, rc[i] | 8'h04, 8'h0});
      chk({hard, init, st}, rx[i]);
      k = 0;
      while ((hard | init | st) === 1'b1 && k < 100)
      begin
        k++;
        @(posedge clock);
        #1;
      end
      chk(k, ccrc_pkg::RST_PULSE_CYC);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
